// file: common/pfc_pkg.sv
// Package of constants, carrier types and helpers for the PID frequency regulator
package pfc_pkg;

	// Serial-bus register offsets and the setpoint-select bit
	localparam logic [15:0] REG_BUS_SETPOINT = 16'h0006;
	localparam logic [15:0] REG_BUS_REFSEL   = 16'h000F;
	localparam int          REFSEL_SP_BIT    = 1;
	localparam logic [15:0] BUS_SETPOINT_RST = 16'h0000;
	localparam logic [15:0] BUS_REFSEL_RST   = 16'h0000;

	// Regulator function select values
	localparam logic [15:0] MODE_OFF      = 16'h0000;
	localparam logic [15:0] MODE_REF_DDEV = 16'h0001;
	localparam logic [15:0] MODE_REF_DFB  = 16'h0002;
	localparam logic [15:0] MODE_ADD_DDEV = 16'h0003;
	localparam logic [15:0] MODE_ADD_DFB  = 16'h0004;

	// Input function codes
	localparam logic [15:0] FN_AIN_SP  = 16'h000C;
	localparam logic [15:0] FN_AIN_FB  = 16'h000B;
	localparam logic [15:0] FN_AIN_DFB = 16'h0016;
	localparam logic [15:0] FN_PLS_SP  = 16'h0002;
	localparam logic [15:0] FN_PLS_FB  = 16'h0001;

	// Signal scale: 0.01 % of maximum output frequency per count
	localparam logic signed [47:0] FULL_SCALE    = 48'sh0000_0000_2710;
	localparam logic signed [47:0] PCT_TO_U      = 48'sh0000_0000_000A;
	localparam logic signed [47:0] GAIN_ONE      = 48'sh0000_0000_0064;
	localparam logic signed [47:0] ITIME_UNIT_US = 48'sh0000_0001_86A0;
	localparam logic signed [47:0] DTIME_UNIT_US = 48'sh0000_0000_2710;
	localparam int                 FRAC          = 16;

	// Settings; gain in 0.01, times in 0.1 s (I) and 0.01 s (D), clamps and offset in 0.1 %
	typedef struct packed {
		logic [15:0]        mode;
		logic [15:0]        gain;
		logic [15:0]        itime;
		logic [15:0]        iclamp;
		logic [15:0]        dtime;
		logic [15:0]        oclamp;
		logic signed [15:0] offset;
		logic               sp_par_en;
		logic [15:0]        sp_par_val;
		logic [2:0][15:0]   ain_fn;
		logic [15:0]        pulse_fn;
	} pfc_cfg_t;

	// Sampled process signals, 0.01 % units, two's complement
	typedef struct packed {
		logic [2:0][15:0] ain;
		logic [15:0]      pulse;
		logic [15:0]      freq_ref;
	} pfc_sig_t;

	localparam pfc_cfg_t CFG_RST = '{
		mode: 16'h0000, gain: 16'h0064, itime: 16'h000A, iclamp: 16'h03E8,
		dtime: 16'h0000, oclamp: 16'h03E8, offset: 16'sh0000, sp_par_en: 1'b0,
		sp_par_val: 16'h0000, ain_fn: 48'h0, pulse_fn: 16'h0000};

	function automatic logic signed [47:0] pfc_sx(input logic [15:0] v);
		return 48'($signed(v));
	endfunction

	function automatic logic signed [47:0] pfc_ux(input logic [15:0] v);
		return $signed({32'h0000_0000, v});
	endfunction

	function automatic logic signed [47:0] pfc_clamp(input logic signed [47:0] v,
		input logic signed [47:0] lim);
		if (v > lim)
			return lim;
		if (v < -lim)
			return -lim;
		return v;
	endfunction

endpackage

// file: rtl/pfc_bus_regs.sv
// Serial-bus setpoint and reference-select registers
`timescale 1ns/1ps
`default_nettype none
module pfc_bus_regs import pfc_pkg::*; (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// Register contents
	output logic      [15:0] bus_setpoint_value,
	output logic      [15:0] bus_reference_select
);

	typedef struct packed {
		logic [15:0] sp;
		logic [15:0] sel;
		logic [15:0] rdata;
	} pfc_bus_st_t;

	pfc_bus_st_t st_r;
	pfc_bus_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (reg_wr && reg_addr == REG_BUS_SETPOINT)
			st_nxt.sp = reg_wdata;
		if (reg_wr && reg_addr == REG_BUS_REFSEL)
			st_nxt.sel = reg_wdata;
		// Unmapped reads answer zero
		if (reg_rd) begin
			case (reg_addr)
				REG_BUS_SETPOINT: st_nxt.rdata = st_r.sp;
				REG_BUS_REFSEL:   st_nxt.rdata = st_r.sel;
				default:          st_nxt.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			st_r <= '{sp: BUS_SETPOINT_RST, sel: BUS_REFSEL_RST, rdata: 16'h0000};
		else
			st_r <= st_nxt;
	end

	assign reg_rdata            = st_r.rdata;
	assign bus_setpoint_value   = st_r.sp;
	assign bus_reference_select = st_r.sel;

endmodule
`default_nettype wire

// file: rtl/pfc_regulator.sv
// PID regulator that sets or trims the drive frequency reference
//
// Contract
// - Function select 0 off, 1..4 on.
// - Modes 1,2: result replaces frequency reference.
// - Modes 3,4: result added to reference.
// - D on deviation (1,3), feedback (2,4).
// - P term is deviation times gain.
// - Integral of deviation; zero time disables.
// - Integrator clamped to percent of maximum.
// - Derivative time zero disables D action.
// - D is slope times derivative time.
// - Total output clamped to percent of maximum.
// - Signed offset added to regulator output.
// - Modes 1,2: reference or assigned setpoint input.
// - Modes 3,4: only assigned setpoint inputs.
// - Analog code C, pulse code 2: setpoint.
// - Bus setpoint used when select bit set.
// - Parameter setpoint used when enable is 1.
// - Duplicate setpoint source raises configuration alarm.
// - Analog code B, pulse code 1: feedback.
// - Duplicate feedback source raises configuration alarm.
// - Analog code 16 enables differential feedback.
// - Duplicate differential source raises configuration alarm.
// - Deviation is setpoint minus feedback.
`timescale 1ns/1ps
`default_nettype none
module pfc_regulator import pfc_pkg::*; #(
	parameter int unsigned TS_US = 1000
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Control-loop sample tick
	input  wire logic        sample_tick,
	// Settings and process signals
	input  wire pfc_cfg_t    cfg,
	input  wire pfc_sig_t    sig,
	// Serial-bus register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// Results
	output logic      [15:0] pid_out,
	output logic      [15:0] freq_out,
	output logic             configuration_error_alarm
);

	// Refused at elaboration: the D scaling divides by the tick period and the I scaling multiplies by it
	if (TS_US < 1 || TS_US > 100000) begin : g_bad_ts
		$error("TS_US must lie in 1..100000");
	end

	localparam logic signed [47:0] TS48 = 48'(TS_US);

	typedef struct packed {
		pfc_cfg_t           cfg;
		logic signed [47:0] integ;
		logic signed [31:0] prev;
		logic signed [15:0] lim;
		logic [15:0]        pid_out;
		logic [15:0]        freq_out;
		logic               alarm;
	} pfc_st_t;

	pfc_st_t st_r;
	pfc_st_t st_nxt;

	logic [15:0] bus_sp;
	logic [15:0] bus_sel;
	logic [2:0]  a_sp;
	logic [2:0]  a_fb;
	logic [2:0]  a_df;
	logic [5:0]  sp_hit;
	logic [3:0]  fb_hit;
	logic [2:0]  sp_cnt;
	logic [2:0]  fb_cnt;
	logic [2:0]  df_cnt;
	logic        mode12;
	logic        mode34;
	logic        d_on_dev;
	logic signed [47:0] dsrc;
	logic signed [47:0] dtm;
	logic signed [47:0] sp;
	logic signed [47:0] fbe;

	pfc_bus_regs u_bus (
		.sys_clk              (sys_clk),
		.resetn               (resetn),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_rdata            (reg_rdata),
		.bus_setpoint_value   (bus_sp),
		.bus_reference_select (bus_sel)
	);

	// Per analog channel source decode
	for (genvar i = 0; i < 3; i++) begin : g_ain
		assign a_sp[i] = st_r.cfg.ain_fn[i] == FN_AIN_SP;
		assign a_fb[i] = st_r.cfg.ain_fn[i] == FN_AIN_FB;
		assign a_df[i] = st_r.cfg.ain_fn[i] == FN_AIN_DFB;
	end

	assign sp_hit = {st_r.cfg.sp_par_en, bus_sel[REFSEL_SP_BIT], a_sp,
		st_r.cfg.pulse_fn == FN_PLS_SP};
	assign fb_hit = {a_fb, st_r.cfg.pulse_fn == FN_PLS_FB};
	assign sp_cnt = 3'($countones(sp_hit));
	assign fb_cnt = 3'($countones(fb_hit));
	assign df_cnt = 3'($countones(a_df));

	assign mode12   = st_r.cfg.mode == MODE_REF_DDEV || st_r.cfg.mode == MODE_REF_DFB;
	assign mode34   = st_r.cfg.mode == MODE_ADD_DDEV || st_r.cfg.mode == MODE_ADD_DFB;
	assign d_on_dev = st_r.cfg.mode == MODE_REF_DDEV || st_r.cfg.mode == MODE_ADD_DDEV;

	// The three dividers are wide and combinational; one sys_clk cycle must cover them
	always_comb begin
		logic signed [47:0] fb;
		logic signed [47:0] fb2;
		logic signed [47:0] dev;
		logic signed [47:0] slope;
		logic signed [47:0] p;
		logic signed [47:0] inc;
		logic signed [47:0] itm;
		logic signed [47:0] sum;
		logic signed [47:0] lim;
		logic signed [47:0] outv;
		fb    = '0;
		fb2   = '0;
		dev   = '0;
		slope = '0;
		p     = '0;
		inc   = '0;
		itm   = '0;
		sum   = '0;
		lim   = '0;
		outv  = '0;
		st_nxt = st_r;
		st_nxt.cfg = cfg;
		st_nxt.alarm = sp_cnt > 3'h1 || fb_cnt > 3'h1 || df_cnt > 3'h1;

		// Lowest priority first, so on a duplicate the later source wins
		sp = mode12 ? pfc_sx(sig.freq_ref) : '0;
		if (st_r.cfg.pulse_fn == FN_PLS_SP)
			sp = pfc_sx(sig.pulse);
		for (int k = 2; k >= 0; k--) begin
			if (a_sp[k])
				sp = pfc_sx(sig.ain[k]);
		end
		if (bus_sel[REFSEL_SP_BIT])
			sp = pfc_sx(bus_sp);
		if (st_r.cfg.sp_par_en)
			sp = pfc_sx(st_r.cfg.sp_par_val);

		if (st_r.cfg.pulse_fn == FN_PLS_FB)
			fb = pfc_sx(sig.pulse);
		for (int k = 2; k >= 0; k--) begin
			if (a_fb[k])
				fb = pfc_sx(sig.ain[k]);
			if (a_df[k])
				fb2 = pfc_sx(sig.ain[k]);
		end
		fbe = (df_cnt != 3'h0) ? fb - fb2 : fb;
		dev = sp - fbe;

		// Rising feedback must brake like a falling deviation
		dsrc  = d_on_dev ? dev : -fbe;
		slope = dsrc - 48'(st_r.prev);
		dtm   = '0;
		if (st_r.cfg.dtime != 16'h0000)
			dtm = slope * pfc_ux(st_r.cfg.dtime) * DTIME_UNIT_US / TS48;

		p = dev * pfc_ux(st_r.cfg.gain) / GAIN_ONE;

		if (sample_tick) begin
			if (!(mode12 || mode34)) begin
				st_nxt.integ    = '0;
				st_nxt.prev     = '0;
				st_nxt.lim      = '0;
				st_nxt.pid_out  = 16'h0000;
				st_nxt.freq_out = sig.freq_ref;
			end else begin
				if (st_r.cfg.itime == 16'h0000) begin
					st_nxt.integ = '0;
				end else begin
					inc = (dev * TS48 <<< FRAC) / (pfc_ux(st_r.cfg.itime) * ITIME_UNIT_US);
					st_nxt.integ = pfc_clamp(st_r.integ + inc,
						(pfc_ux(st_r.cfg.iclamp) * PCT_TO_U) <<< FRAC);
				end
				itm = st_nxt.integ >>> FRAC;
				st_nxt.prev = 32'(dsrc);
				sum  = p + itm + dtm;
				lim  = pfc_clamp(sum, pfc_ux(st_r.cfg.oclamp) * PCT_TO_U);
				outv = pfc_clamp(lim + pfc_sx(st_r.cfg.offset) * PCT_TO_U,
					FULL_SCALE);
				st_nxt.lim     = 16'(lim);
				st_nxt.pid_out = 16'(outv);
				if (mode12)
					st_nxt.freq_out = 16'(outv);
				else
					st_nxt.freq_out = 16'(pfc_clamp(pfc_sx(sig.freq_ref) + outv,
						FULL_SCALE));
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			st_r <= '{cfg: CFG_RST, integ: '0, prev: '0, lim: '0,
				pid_out: 16'h0000, freq_out: 16'h0000, alarm: 1'b0};
		else
			st_r <= st_nxt;
	end

	assign pid_out                   = st_r.pid_out;
	assign freq_out                  = st_r.freq_out;
	assign configuration_error_alarm = st_r.alarm;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence tick_off;
		sample_tick && !(mode12 || mode34);
	endsequence

	sequence tick_replace;
		sample_tick && mode12;
	endsequence

	sequence tick_trim;
		sample_tick && mode34;
	endsequence

	mode_off_a: assert property (
		tick_off |=> pid_out == 16'h0000 && freq_out == $past(sig.freq_ref))
		else $error("disabled regulator drives a result");

	ref_replace_a: assert property (
		tick_replace |=> freq_out == pid_out)
		else $error("result does not replace reference");

	ref_trim_a: assert property (
		tick_trim |=> freq_out == 16'(pfc_clamp(pfc_sx($past(sig.freq_ref))
			+ pfc_sx(pid_out), FULL_SCALE)))
		else $error("result not added to reference");

	integ_off_a: assert property (
		sample_tick && st_r.cfg.itime == 16'h0000 |=> st_r.integ == '0)
		else $error("integrator runs with zero time");

	integ_clamp_a: assert property (
		sample_tick |=> (st_r.integ >>> FRAC) <= pfc_ux($past(st_r.cfg.iclamp)) * PCT_TO_U
			&& (st_r.integ >>> FRAC) >= -(pfc_ux($past(st_r.cfg.iclamp)) * PCT_TO_U))
		else $error("integrator beyond its clamp");

	deriv_off_a: assert property (
		st_r.cfg.dtime == 16'h0000 |-> dtm == '0)
		else $error("derivative acts with zero time");

	out_clamp_a: assert property (
		sample_tick |=> pfc_sx(st_r.lim) <= pfc_ux($past(st_r.cfg.oclamp)) * PCT_TO_U
			&& pfc_sx(st_r.lim) >= -(pfc_ux($past(st_r.cfg.oclamp)) * PCT_TO_U))
		else $error("output beyond its clamp");

	out_offset_a: assert property (
		sample_tick && (mode12 || mode34) |=> pid_out == 16'(pfc_clamp(pfc_sx(st_r.lim)
			+ pfc_sx($past(st_r.cfg.offset)) * PCT_TO_U, FULL_SCALE)))
		else $error("offset not applied");

	sp_dup_a: assert property (
		sp_cnt > 3'h1 |=> configuration_error_alarm)
		else $error("duplicate setpoint not flagged");

	fb_dup_a: assert property (
		fb_cnt > 3'h1 |=> configuration_error_alarm)
		else $error("duplicate feedback not flagged");

	df_dup_a: assert property (
		df_cnt > 3'h1 |=> configuration_error_alarm)
		else $error("duplicate differential not flagged");

	alarm_clear_a: assert property (
		sp_cnt <= 3'h1 && fb_cnt <= 3'h1 && df_cnt <= 3'h1 |=> !configuration_error_alarm)
		else $error("alarm without a duplicate");

	// Results stand between ticks, so a stray strobe shows up at once
	out_hold_a: assert property (
		!sample_tick |=> $stable(pid_out) && $stable(freq_out))
		else $error("result moved without a tick");

	sp_param_a: assert property (
		st_r.cfg.sp_par_en |-> sp == pfc_sx(st_r.cfg.sp_par_val))
		else $error("parameter setpoint not used");

	sp_bus_a: assert property (
		bus_sel[REFSEL_SP_BIT] && !st_r.cfg.sp_par_en |-> sp == pfc_sx(bus_sp))
		else $error("bus setpoint not used");

	sp_trim_a: assert property (
		mode34 && sp_cnt == 3'h0 |-> sp == '0)
		else $error("trim mode setpoint not from an assigned input");

endmodule
`default_nettype wire

// file: verification/pfc_far_side.sv
// Far-side model: process sensors and the serial-bus master
`timescale 1ns/1ps
`default_nettype none
module pfc_far_side import pfc_pkg::*; (
	// Clock
	input  wire logic        sys_clk,
	// Sensors
	output var pfc_sig_t     sig,
	// Serial-bus master
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_addr,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata
);
	initial begin
		sig = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end
	// One access a call; released address and data lines show the inverse, never the stale value
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge sys_clk);
		#1;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge sys_clk);
		#1;
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// Value before select bit, so a selected setpoint is never stale
	task automatic set_bus(input logic [15:0] v, input logic [15:0] sel);
		logic [15:0] q;
		acc(1'b1, REG_BUS_SETPOINT, v, q);
		acc(1'b1, REG_BUS_REFSEL, sel, q);
	endtask
	task automatic set_sig(input pfc_sig_t s);
		@(posedge sys_clk);
		#1;
		sig = s;
	endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench of the regulator against an integer model
`timescale 1ns/1ps
`default_nettype none
module testbench import pfc_pkg::*;;
	localparam int TS = 1000;
	logic        sys_clk;
	logic        resetn;
	logic        sample_tick;
	pfc_cfg_t    cfg;
	pfc_sig_t    sig;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [15:0] pid_out;
	logic [15:0] freq_out;
	logic        alarm;
	logic [15:0] bus_sp;
	logic [15:0] bus_sel;
	int          err_total;
	int          n_checks;
	longint      iacc;
	longint      dprev;
	logic [15:0] afn[4];
	logic [15:0] pfn[3];
	longint      exp_q[$];

	pfc_regulator #(.TS_US(TS)) dut (
		.sys_clk(sys_clk), .resetn(resetn), .sample_tick(sample_tick), .cfg(cfg), .sig(sig),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pid_out(pid_out), .freq_out(freq_out),
		.configuration_error_alarm(alarm));
	pfc_far_side far (
		.sys_clk(sys_clk), .sig(sig), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	function automatic longint sx(input logic [15:0] v);
		return longint'($signed(v));
	endfunction
	function automatic longint lim(input longint v, input longint l);
		return (v > l) ? l : ((v < -l) ? -l : v);
	endfunction
	// Multiples of 100 keep every scaled term exact, so no rounding guess is needed
	function automatic logic [15:0] rv();
		return 16'((int'($urandom_range(0, 200)) - 100) * 100);
	endfunction

	task automatic model(output longint pid, output longint fo);
		longint sp;
		longint fb;
		longint fb2;
		longint dev;
		longint x;
		longint di;
		logic   on;
		on = cfg.mode inside {[MODE_REF_DDEV:MODE_ADD_DFB]};
		sp = (cfg.mode <= MODE_REF_DFB) ? sx(sig.freq_ref) : 0;
		fb = 0;
		fb2 = 0;
		if (cfg.pulse_fn === FN_PLS_SP)
			sp = sx(sig.pulse);
		if (cfg.pulse_fn === FN_PLS_FB)
			fb = sx(sig.pulse);
		for (int k = 2; k >= 0; k--) begin
			if (cfg.ain_fn[k] === FN_AIN_SP)
				sp = sx(sig.ain[k]);
			if (cfg.ain_fn[k] === FN_AIN_FB)
				fb = sx(sig.ain[k]);
			if (cfg.ain_fn[k] === FN_AIN_DFB)
				fb2 = sx(sig.ain[k]);
		end
		if (bus_sel[REFSEL_SP_BIT])
			sp = sx(bus_sp);
		if (cfg.sp_par_en)
			sp = sx(cfg.sp_par_val);
		fb = fb - fb2;
		dev = sp - fb;
		x = (cfg.mode == MODE_REF_DFB || cfg.mode == MODE_ADD_DFB) ? -fb : dev;
		if (!on || cfg.itime == 0)
			iacc = 0;
		else
			iacc = lim(iacc + dev * TS * 65536 / (longint'(cfg.itime) * 100000),
				longint'(cfg.iclamp) * 655360);
		di = (cfg.dtime == 0) ? 0 : (x - dprev) * longint'(cfg.dtime) * 10000 / TS;
		dprev = on ? x : 0;
		pid = on ? lim(lim(dev * longint'(cfg.gain) / 100 + (iacc >>> 16) + di,
			longint'(cfg.oclamp) * 10) + sx(cfg.offset) * 10, 10000) : 0;
		fo = !on ? sx(sig.freq_ref) : (cfg.mode <= MODE_REF_DFB) ? pid
			: lim(sx(sig.freq_ref) + pid, 10000);
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick();
		longint p;
		longint f;
		@(posedge sys_clk);
		#1;
		sample_tick = 1'b1;
		model(p, f);
		exp_q.push_back(p);
		exp_q.push_back(f);
		@(posedge sys_clk);
		#1;
		sample_tick = 1'b0;
		@(posedge sys_clk);
		#1;
		chk("pid_out", 16'(exp_q.pop_front()), pid_out);
		chk("freq_out", 16'(exp_q.pop_front()), freq_out);
	endtask
	task automatic apply(input pfc_cfg_t c);
		int s;
		int f;
		int d;
		@(posedge sys_clk);
		#1;
		cfg = c;
		repeat (3) @(posedge sys_clk);
		#1;
		s = int'(c.sp_par_en) + int'(bus_sel[REFSEL_SP_BIT]) + int'(c.pulse_fn === FN_PLS_SP);
		f = int'(c.pulse_fn === FN_PLS_FB);
		d = 0;
		for (int k = 0; k < 3; k++) begin
			s += int'(c.ain_fn[k] === FN_AIN_SP);
			f += int'(c.ain_fn[k] === FN_AIN_FB);
			d += int'(c.ain_fn[k] === FN_AIN_DFB);
		end
		chk("alarm", 16'(s > 1 || f > 1 || d > 1), 16'(alarm));
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		close_out();
	end

	initial begin
		logic [15:0] q;
		logic [15:0] v;
		logic [15:0] a;
		pfc_cfg_t    c;
		pfc_sig_t    s;
		void'($urandom(16));
		afn = '{16'h0000, FN_AIN_FB, FN_AIN_SP, FN_AIN_DFB};
		pfn = '{16'h0000, FN_PLS_FB, FN_PLS_SP};
		resetn = 1'b0;
		sample_tick = 1'b0;
		cfg = CFG_RST;
		bus_sp = 16'h0000;
		bus_sel = 16'h0000;
		iacc = 0;
		dprev = 0;
		err_total = 0;
		n_checks = 0;
		repeat (20) @(posedge sys_clk);
		#1;
		chk("pid_out", 16'h0000, pid_out);
		chk("freq_out", 16'h0000, freq_out);
		resetn = 1'b1;
		repeat (2) @(posedge sys_clk);
		far.acc(1'b0, REG_BUS_REFSEL, 16'h0000, q);
		chk("select reg", BUS_REFSEL_RST, q);
		for (int n = 0; n < 36; n++) begin
			v = rv();
			a = 16'($urandom());
			far.set_bus(v, a);
			bus_sp = v;
			bus_sel = a;
			far.acc(1'b1, 16'($urandom_range(16, 65535)), 16'($urandom()), q);
			far.acc(1'b0, 16'($urandom_range(16, 65535)), 16'h0000, q);
			chk("unmapped reg", 16'h0000, q);
			far.acc(1'b0, REG_BUS_REFSEL, 16'h0000, q);
			chk("select reg", a, q);
			far.acc(1'b0, REG_BUS_SETPOINT, 16'h0000, q);
			chk("setpoint reg", v, q);
			c.mode = MODE_OFF;
			c.gain = 16'($urandom_range(0, 2500));
			c.itime = 16'($urandom_range(0, 1));
			c.iclamp = 16'($urandom_range(0, 1000));
			c.dtime = 16'($urandom_range(0, 3));
			c.oclamp = 16'($urandom_range(0, 1000));
			c.offset = 16'(int'($urandom_range(0, 2000)) - 1000);
			c.sp_par_en = 1'($urandom_range(0, 1));
			c.sp_par_val = rv();
			foreach (c.ain_fn[k])
				c.ain_fn[k] = afn[$urandom_range(0, 3)];
			c.pulse_fn = pfn[$urandom_range(0, 2)];
			apply(c);
			tick();
			c.mode = 16'(n % 6);
			apply(c);
			repeat (3) begin
				foreach (s.ain[k])
					s.ain[k] = rv();
				s.pulse = rv();
				s.freq_ref = rv();
				far.set_sig(s);
				tick();
			end
		end
		close_out();
	end
endmodule
`default_nettype wire
